// file: design/lts_defs.svh
// Offsets, field positions, reset values and timing counts of the line test setup block.
// Assumes a 100 MHz system clock and an APB slave decoding 8 address bits.
`ifndef LTS_DEFS_SVH
`define LTS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LTS_ADDR_MODE 8'h00
`define LTS_ADDR_STORE 8'h04
`define LTS_ADDR_BCS 8'h08
`define LTS_ADDR_LEADS 8'h0C
`define LTS_ADDR_STATUS 8'h10
`define LTS_ADDR_CNT_A 8'h14
`define LTS_ADDR_CNT_B 8'h18
`define LTS_ADDR_ACC 8'h1C
`define LTS_ADDR_PARAM 8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LTS_MODE_ARG_LSB 0
`define LTS_MODE_ARG_MSB 1
`define LTS_MODE_HAS_ARG 2
`define LTS_LEAD_RTS 0
`define LTS_LEAD_CTS 1
`define LTS_LEAD_DCD 2
`define LTS_LEAD_RI 3
`define LTS_ST_BUSY 2
`define LTS_ST_OVERWRITE 3
`define LTS_ST_DISPLAY 4
`define LTS_ST_PARITY 5
`define LTS_ST_RX2 6
`define LTS_ST_RX3 7
`define LTS_PARAM_PAR_ODD 0

// ----------------------------------------------------------------
// Reset values and check polynomials
// ----------------------------------------------------------------
`define LTS_PARAM_RST 32'h0000_0000
`define LTS_LEADS_RST 4'h0
`define LTS_POLY_CRC16 16'h8005
`define LTS_POLY_CCITT 16'h1021
`define LTS_ACC_ONES 16'hFFFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LTS_CLK_MHZ 100
`define LTS_MODE_US 32
`define LTS_MODE_CYC (`LTS_MODE_US * `LTS_CLK_MHZ)
`define LTS_STORE_MS 4
`define LTS_STORE_CYC (`LTS_STORE_MS * 1000 * `LTS_CLK_MHZ)
`define LTS_CLK_HALF 8

`endif

// file: design/lts_pkg.sv
// Types shared by the line test setup block.
// Assumes lts_defs.svh is compiled alongside it.
`default_nettype none
package lts_pkg;
  typedef enum logic [1:0] {
    LTS_MODE_BRIDGE = 2'h0,
    LTS_MODE_MODEM = 2'h1,
    LTS_MODE_TERM = 2'h2,
    LTS_MODE_ALL = 2'h3
  } lts_mode_t;

  typedef enum logic [1:0] {
    LTS_BCS_LRC_PAR = 2'h0,
    LTS_BCS_LRC_RAW = 2'h1,
    LTS_BCS_CRC16 = 2'h2,
    LTS_BCS_CCITT = 2'h3
  } lts_bcs_t;

  typedef enum {
    LTS_ST_IDLE,
    LTS_ST_MODE_CHG,
    LTS_ST_STORE
  } lts_state_t;
endpackage
`default_nettype wire

// file: design/lts_setup.sv
// Line test mode setup: mode select, lead drive, stored parameters, block check.
// Assumes an APB master on sys_clk and RS-232 lead pins resolved by the bench.
//
// Functional notes
// - Bridge mode watches both data leads and drives neither.
// - Without a mode choice or argument the block bridges both data leads.
// - Modem mode receives on lead 2 and transmits on lead 3.
// - Terminal mode receives on lead 3 and transmits on lead 2.
// - All mode runs modem and terminal simulation together for self-test.
// - A mode change starts a sync search on its receiving leads.
// - Terminal simulation drives transmit data and asserts terminal ready.
// - Modem simulation asserts set ready and supplies both timing clocks.
// - Program drives request-to-send or modem leads; mode change takes 32 us.
// - Storing parameters sets overwrite, clears counters and parity, enables display.
// - Four check schemes: corrected LRC, raw LRC, CRC-16, CRC-CCITT.
// - LRC and CRC-16 schemes clear the accumulator; CRC-CCITT presets all ones.
`default_nettype none
`include "lts_defs.svh"
module lts_setup #(
  parameter int STORE_CYCLES = `LTS_STORE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_data,
  input wire logic parity_err_in,
  input wire logic lead2_in,
  input wire logic lead3_in,
  input wire logic lead17_in,
  output var logic lead2_o,
  output var logic lead2_oe_n,
  output var logic lead3_o,
  output var logic lead3_oe_n,
  output var logic lead4_o,
  output var logic lead4_oe_n,
  output var logic lead5_o,
  output var logic lead5_oe_n,
  output var logic lead6_o,
  output var logic lead6_oe_n,
  output var logic lead8_o,
  output var logic lead8_oe_n,
  output var logic lead15_o,
  output var logic lead15_oe_n,
  output var logic lead17_o,
  output var logic lead17_oe_n,
  output var logic lead20_o,
  output var logic lead20_oe_n,
  output var logic lead22_o,
  output var logic lead22_oe_n,
  output var logic rx2_en,
  output var logic rx3_en,
  output var logic sync_search
);
  localparam logic [31:0] MODE_CYC = 32'(`LTS_MODE_CYC);
  localparam logic [31:0] STORE_CYC = 32'(STORE_CYCLES);
  localparam logic [3:0] HALF = 4'(`LTS_CLK_HALF);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [3:0] pin_s;
  logic s_par, s_rxc, s_l2, s_l3;

  lts_sync #(.W(4)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in({parity_err_in, lead17_in, lead2_in, lead3_in}),
    .pin_sync(pin_s)
  );
  assign {s_par, s_rxc, s_l2, s_l3} = pin_s;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lts_pkg::lts_state_t state_reg, state_next;
  lts_pkg::lts_mode_t mode_reg, mode_next, pend_reg, pend_next;
  lts_pkg::lts_bcs_t bcs_reg, bcs_next;
  logic [31:0] cnt_reg, cnt_next, param_reg, param_next, applied_reg, applied_next;
  logic [31:0] prdata_next;
  logic [15:0] acc_reg, acc_next, cnt_a_reg, cnt_a_next, cnt_b_reg, cnt_b_next;
  logic [3:0] leads_reg, leads_next, div_reg, div_next;
  logic [2:0] idx_reg, idx_next;
  logic txc_reg, txc_next, rxc_prev_reg, own_rise;
  logic overwrite_reg, overwrite_next, display_reg, display_next, par_reg, par_next;
  logic sync_next, rx2_next, rx3_next;
  logic wr, rd, busy, hit, drv_ok, sim_m, sim_t, bit_stb, rx_bit;
  logic [7:0] lrc_fix;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign busy = state_reg != lts_pkg::LTS_ST_IDLE;
  assign hit = paddr inside {`LTS_ADDR_MODE, `LTS_ADDR_STORE, `LTS_ADDR_BCS,
    `LTS_ADDR_LEADS, `LTS_ADDR_STATUS, `LTS_ADDR_CNT_A, `LTS_ADDR_CNT_B,
    `LTS_ADDR_ACC, `LTS_ADDR_PARAM};
  // Zero wait states; commands refused while a previous one is still running
  assign pready = 1'b1;
  assign pslverr = psel && penable && (!hit || (pwrite && busy &&
    (paddr == `LTS_ADDR_MODE || paddr == `LTS_ADDR_STORE)));

  assign drv_ok = state_reg != lts_pkg::LTS_ST_MODE_CHG;
  assign sim_m = drv_ok && (mode_reg == lts_pkg::LTS_MODE_MODEM ||
    mode_reg == lts_pkg::LTS_MODE_ALL);
  assign sim_t = drv_ok && (mode_reg == lts_pkg::LTS_MODE_TERM ||
    mode_reg == lts_pkg::LTS_MODE_ALL);
  assign own_rise = div_reg == HALF - 4'h1 && !txc_reg;
  // Own clock while simulating the modem, otherwise the far end's receive clock
  assign bit_stb = sim_m ? own_rise : (s_rxc && !rxc_prev_reg);
  assign rx_bit = rx3_en ? s_l3 : s_l2;

  // ----------------------------------------------------------------
  // Block check step
  // ----------------------------------------------------------------
  function automatic logic [15:0] bcs_step(input logic [15:0] acc, input logic b,
                                           input logic [2:0] idx,
                                           input lts_pkg::lts_bcs_t t);
    logic fb;
    logic [15:0] r;
    fb = acc[15] ^ b;
    r = acc;
    case (t)
      lts_pkg::LTS_BCS_CRC16: r = {acc[14:0], 1'b0} ^ (fb ? `LTS_POLY_CRC16 : 16'h0000);
      lts_pkg::LTS_BCS_CCITT: r = {acc[14:0], 1'b0} ^ (fb ? `LTS_POLY_CCITT : 16'h0000);
      default: r[idx] = acc[idx] ^ b;
    endcase
    return r;
  endfunction

  // Parity-corrected LRC follows the applied parity, not a pending edit
  assign lrc_fix = {^acc_reg[6:0] ^ applied_reg[`LTS_PARAM_PAR_ODD], acc_reg[6:0]};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    pend_next = pend_reg;
    cnt_next = cnt_reg;
    sync_next = 1'b0;
    param_next = param_reg;
    applied_next = applied_reg;
    overwrite_next = overwrite_reg;
    display_next = display_reg;
    par_next = par_reg;
    cnt_a_next = cnt_a_reg;
    cnt_b_next = cnt_b_reg;
    leads_next = leads_reg;
    bcs_next = bcs_reg;
    acc_next = acc_reg;
    idx_next = idx_reg;
    case (state_reg)
      lts_pkg::LTS_ST_IDLE: begin
        if (wr && paddr == `LTS_ADDR_MODE) begin
          state_next = lts_pkg::LTS_ST_MODE_CHG;
          cnt_next = MODE_CYC - 32'h1;
          pend_next = pwdata[`LTS_MODE_HAS_ARG] ?
            lts_pkg::lts_mode_t'(pwdata[`LTS_MODE_ARG_MSB:`LTS_MODE_ARG_LSB]) :
            lts_pkg::LTS_MODE_BRIDGE;
        end else if (wr && paddr == `LTS_ADDR_STORE) begin
          state_next = lts_pkg::LTS_ST_STORE;
          cnt_next = STORE_CYC - 32'h1;
          applied_next = param_reg;
          overwrite_next = 1'b1;
          display_next = 1'b1;
          cnt_a_next = 16'h0000;
          cnt_b_next = 16'h0000;
        end
      end
      lts_pkg::LTS_ST_MODE_CHG: begin
        cnt_next = cnt_reg - 32'h1;
        if (cnt_reg == 32'h0) begin
          state_next = lts_pkg::LTS_ST_IDLE;
          mode_next = pend_reg;
          sync_next = 1'b1;
        end
      end
      lts_pkg::LTS_ST_STORE: begin
        cnt_next = cnt_reg - 32'h1;
        if (cnt_reg == 32'h0) begin
          state_next = lts_pkg::LTS_ST_IDLE;
        end
      end
      default: state_next = lts_pkg::LTS_ST_IDLE;
    endcase
    // Counting stops while a command runs, so a store's clear is never undone
    if (bit_stb && rx2_en && state_next == lts_pkg::LTS_ST_IDLE) begin
      cnt_a_next = cnt_a_reg + 16'h1;
    end
    if (bit_stb && rx3_en && state_next == lts_pkg::LTS_ST_IDLE) begin
      cnt_b_next = cnt_b_reg + 16'h1;
    end
    if (wr && paddr == `LTS_ADDR_PARAM) begin
      param_next = pwdata;
    end
    if (wr && paddr == `LTS_ADDR_LEADS) begin
      leads_next = pwdata[3:0];
    end
    if (wr && !busy && paddr == `LTS_ADDR_STORE) begin
      par_next = 1'b0;
    end
    if (s_par) begin
      par_next = 1'b1;
    end
    if (wr && paddr == `LTS_ADDR_BCS) begin
      bcs_next = lts_pkg::lts_bcs_t'(pwdata[1:0]);
      acc_next = pwdata[1:0] == 2'h3 ? `LTS_ACC_ONES : 16'h0000;
      idx_next = 3'h0;
    end else if (bit_stb && (rx2_en || rx3_en)) begin
      acc_next = bcs_step(acc_reg, rx_bit, idx_reg, bcs_reg);
      idx_next = idx_reg + 3'h1;
    end
    if (!rst_n) begin
      state_next = lts_pkg::LTS_ST_IDLE;
      mode_next = lts_pkg::LTS_MODE_BRIDGE;
      pend_next = lts_pkg::LTS_MODE_BRIDGE;
      cnt_next = 32'h0;
      sync_next = 1'b0;
      param_next = `LTS_PARAM_RST;
      applied_next = `LTS_PARAM_RST;
      overwrite_next = 1'b0;
      display_next = 1'b0;
      par_next = 1'b0;
      cnt_a_next = 16'h0000;
      cnt_b_next = 16'h0000;
      leads_next = `LTS_LEADS_RST;
      bcs_next = lts_pkg::LTS_BCS_LRC_PAR;
      acc_next = 16'h0000;
      idx_next = 3'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
    mode_reg <= mode_next;
    pend_reg <= pend_next;
    cnt_reg <= cnt_next;
    sync_search <= sync_next;
    param_reg <= param_next;
    applied_reg <= applied_next;
    overwrite_reg <= overwrite_next;
    display_reg <= display_next;
    par_reg <= par_next;
    cnt_a_reg <= cnt_a_next;
    cnt_b_reg <= cnt_b_next;
    leads_reg <= leads_next;
    bcs_reg <= bcs_next;
    acc_reg <= acc_next;
    idx_reg <= idx_next;
  end

  // ----------------------------------------------------------------
  // Timing clock divider and lead drive
  // ----------------------------------------------------------------
  always_comb begin
    div_next = div_reg == HALF - 4'h1 ? 4'h0 : div_reg + 4'h1;
    txc_next = div_reg == HALF - 4'h1 ? !txc_reg : txc_reg;
    rx2_next = drv_ok && mode_reg != lts_pkg::LTS_MODE_TERM;
    rx3_next = drv_ok && mode_reg != lts_pkg::LTS_MODE_MODEM;
    if (!rst_n) begin
      div_next = 4'h0;
      txc_next = 1'b0;
      rx2_next = 1'b0;
      rx3_next = 1'b0;
    end
  end

  // Bridge mode leaves every enable high: a passive tap never fights the line
  always_ff @(posedge sys_clk) begin
    div_reg <= div_next;
    txc_reg <= txc_next;
    rxc_prev_reg <= rst_n ? s_rxc : 1'b0;
    rx2_en <= rx2_next;
    rx3_en <= rx3_next;
    lead2_o <= tx_data;
    lead2_oe_n <= !(rst_n && sim_t);
    lead3_o <= tx_data;
    lead3_oe_n <= !(rst_n && sim_m);
    lead20_o <= 1'b1;
    lead20_oe_n <= !(rst_n && sim_t);
    lead4_o <= leads_reg[`LTS_LEAD_RTS];
    lead4_oe_n <= !(rst_n && sim_t);
    lead6_o <= 1'b1;
    lead6_oe_n <= !(rst_n && sim_m);
    lead5_o <= leads_reg[`LTS_LEAD_CTS];
    lead5_oe_n <= !(rst_n && sim_m);
    lead8_o <= leads_reg[`LTS_LEAD_DCD];
    lead8_oe_n <= !(rst_n && sim_m);
    lead22_o <= leads_reg[`LTS_LEAD_RI];
    lead22_oe_n <= !(rst_n && sim_m);
    lead15_o <= txc_next;
    lead15_oe_n <= !(rst_n && sim_m);
    lead17_o <= txc_next;
    lead17_oe_n <= !(rst_n && sim_m);
  end

  // ----------------------------------------------------------------
  // APB read data
  // ----------------------------------------------------------------
  always_comb begin
    prdata_next = prdata;
    if (rd) begin
      case (paddr)
        `LTS_ADDR_MODE: prdata_next = {30'h0, mode_reg};
        `LTS_ADDR_BCS: prdata_next = {30'h0, bcs_reg};
        `LTS_ADDR_LEADS: prdata_next = {28'h0, leads_reg};
        `LTS_ADDR_STATUS: prdata_next = {24'h0, rx3_en, rx2_en, par_reg, display_reg,
          overwrite_reg, busy, mode_reg};
        `LTS_ADDR_CNT_A: prdata_next = {16'h0, cnt_a_reg};
        `LTS_ADDR_CNT_B: prdata_next = {16'h0, cnt_b_reg};
        `LTS_ADDR_ACC: prdata_next = bcs_reg == lts_pkg::LTS_BCS_LRC_PAR ?
          {24'h0, lrc_fix} : {16'h0, acc_reg};
        `LTS_ADDR_PARAM: prdata_next = applied_reg;
        default: prdata_next = 32'h0;
      endcase
    end
    if (!rst_n) begin
      prdata_next = 32'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    prdata <= prdata_next;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence mode_go;
    wr && paddr == `LTS_ADDR_MODE && !busy;
  endsequence
  sequence store_go;
    wr && paddr == `LTS_ADDR_STORE && !busy;
  endsequence

  bridge_passive_a: assert property (mode_reg == lts_pkg::LTS_MODE_BRIDGE |=>
    lead2_oe_n && lead3_oe_n) else $error("bridge mode drove a data lead");
  noarg_bridge_a: assert property (mode_go ##0 !pwdata[`LTS_MODE_HAS_ARG] |=>
    pend_reg == lts_pkg::LTS_MODE_BRIDGE) else $error("no argument did not bridge");
  modem_tx_a: assert property (sim_m |=> !lead3_oe_n && lead3_o == $past(tx_data)
    && rx2_en) else $error("modem simulation not on lead 3");
  term_tx_a: assert property (sim_t |=> !lead2_oe_n && !lead20_oe_n && lead20_o
    && rx3_en) else $error("terminal simulation leads wrong");
  all_both_a: assert property (mode_reg == lts_pkg::LTS_MODE_ALL && drv_ok |=>
    !lead2_oe_n && !lead3_oe_n) else $error("all mode not driving both");
  sync_start_a: assert property (sync_search |-> $past(state_reg) ==
    lts_pkg::LTS_ST_MODE_CHG && $past(cnt_reg) == 32'h0) else $error("stray sync search");
  modem_clk_a: assert property (sim_m |=> !lead6_oe_n && !lead15_oe_n &&
    !lead17_oe_n && lead15_o == lead17_o) else $error("modem clocks not supplied");
  mode_time_a: assert property (mode_go |=> cnt_reg == MODE_CYC - 32'h1)
    else $error("mode change time wrong");
  store_effect_a: assert property (store_go |=> overwrite_reg && display_reg &&
    cnt_a_reg == 16'h0 && cnt_b_reg == 16'h0) else $error("store effects missing");
  bcs_preset_a: assert property (wr && paddr == `LTS_ADDR_BCS |=> acc_reg ==
    (bcs_reg == lts_pkg::LTS_BCS_CCITT ? `LTS_ACC_ONES : 16'h0000))
    else $error("check accumulator not preset");
  change_quiet_a: assert property (state_reg == lts_pkg::LTS_ST_MODE_CHG |=>
    lead2_oe_n && lead3_oe_n && lead20_oe_n && lead6_oe_n)
    else $error("lead driven during mode change");
endmodule
`default_nettype wire

// file: design/lts_sync.sv
// Two flip-flop synchroniser for pins arriving from outside sys_clk.
// Assumes each bit is an independent level; no bus coherence is kept.
`default_nettype none
module lts_sync #(
  parameter int W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output var logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    if (!rst_n) begin
      meta_next = '0;
      sync_next = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    meta_reg <= meta_next;
    pin_sync <= sync_next;
  end
endmodule
`default_nettype wire

// file: verif/line_test_mode_setup_test.sv
// Bench for the line test setup block: APB sequences with expected values.
// Assumes lts_defs.svh and lts_pkg are compiled first.
`default_nettype none
`include "lts_defs.svh"
module line_test_mode_setup_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, b, tx_data = 1'b1, parity_err_in = 1'b0, frame_on = 1'b0;
  logic lead2_in, lead3_in, lead17_in, rx2_en, rx3_en, sync_search;
  logic lead2_o, lead3_o, lead4_o, lead5_o, lead6_o, lead8_o, lead15_o, lead17_o;
  logic lead20_o, lead22_o, lead2_oe_n, lead3_oe_n, lead4_oe_n, lead5_oe_n, lead6_oe_n;
  logic lead8_oe_n, lead15_oe_n, lead17_oe_n, lead20_oe_n, lead22_oe_n;
  logic [9:0] drv;
  logic [1:0] em;
  logic [2:0] mw [5] = '{3'h5, 3'h6, 3'h7, 3'h4, 3'h2};
  int err_total = 0, cmp_count = 0, n, cyc;
  time t0;
  assign drv = ~{lead2_oe_n, lead3_oe_n, lead4_oe_n, lead5_oe_n, lead6_oe_n, lead8_oe_n,
                 lead15_oe_n, lead17_oe_n, lead20_oe_n, lead22_oe_n};
  // Short store time keeps the run brief
  lts_setup #(.STORE_CYCLES(20)) i_lts_setup (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .parity_err_in(parity_err_in),
    .lead2_in(lead2_in), .lead3_in(lead3_in), .lead17_in(lead17_in), .lead2_o(lead2_o),
    .lead2_oe_n(lead2_oe_n), .lead3_o(lead3_o), .lead3_oe_n(lead3_oe_n), .lead4_o(lead4_o),
    .lead4_oe_n(lead4_oe_n), .lead5_o(lead5_o), .lead5_oe_n(lead5_oe_n), .lead6_o(lead6_o),
    .lead6_oe_n(lead6_oe_n), .lead8_o(lead8_o), .lead8_oe_n(lead8_oe_n), .lead15_o(lead15_o),
    .lead15_oe_n(lead15_oe_n), .lead17_o(lead17_o), .lead17_oe_n(lead17_oe_n),
    .lead20_o(lead20_o), .lead20_oe_n(lead20_oe_n), .lead22_o(lead22_o),
    .lead22_oe_n(lead22_oe_n), .rx2_en(rx2_en), .rx3_en(rx3_en), .sync_search(sync_search));
  lts_far_end i_lts_far_end (.frame_on(frame_on), .lead2_o(lead2_o), .lead2_oe_n(lead2_oe_n),
    .lead3_o(lead3_o), .lead3_oe_n(lead3_oe_n), .lead2_in(lead2_in), .lead3_in(lead3_in),
    .lead17_in(lead17_in));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk({31'h0, pready}, 32'h1, "bus answer");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [9:0] mask(input logic [1:0] m);
    case (m)
      lts_pkg::LTS_MODE_MODEM: return 10'h17D;
      lts_pkg::LTS_MODE_TERM: return 10'h282;
      lts_pkg::LTS_MODE_ALL: return 10'h3FF;
      default: return 10'h000;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({20'h0, drv, rx2_en, rx3_en}, 32'h3, "reset bridge");
    apb(1'b0, 8'h40, 32'h0);
    chk({q[30:0], e}, 32'h1, "unmapped read");
    for (int i = 0; i < 5; i++) begin
      em = mw[i][2] ? mw[i][1:0] : 2'h0;
      apb(1'b1, `LTS_ADDR_MODE, {29'h0, mw[i]});
      t0 = $time;
      apb(1'b0, `LTS_ADDR_STATUS, 32'h0);
      chk({31'h0, q[`LTS_ST_BUSY]}, 32'h1, "busy");
      apb(1'b1, `LTS_ADDR_MODE, 32'h5);
      chk({31'h0, e}, 32'h1, "write while busy");
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
        if (n == 100) chk({20'h0, drv, rx2_en, rx3_en}, 32'h0, "leads during change");
      end while (sync_search !== 1'b1 && n < 4000);
      cyc = int'(($time - t0) / 10);
      chk({31'h0, cyc >= 3195 && cyc <= 3205}, 32'h1, "change time");
      @(posedge sys_clk);
      #1;
      chk({31'h0, sync_search}, 32'h0, "sync pulse");
      chk({22'h0, drv}, {22'h0, mask(em)}, "lead drive");
      chk({30'h0, rx2_en, rx3_en}, {30'h0, em != 2'h2, em != 2'h1}, "rx");
      if (em[1]) chk({30'h0, lead2_o, lead20_o}, 32'h3, "terminal leads");
      if (em[0]) begin
        chk({30'h0, lead3_o, lead6_o}, 32'h3, "modem leads");
        b = lead15_o;
        repeat (8) @(posedge sys_clk);
        #1;
        chk({30'h0, lead15_o ^ b, lead17_o ^ b}, 32'h3, "timing clocks");
        @(posedge sys_clk);
        tx_data <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({31'h0, lead3_o}, 32'h0, "modem tx data");
        @(posedge sys_clk);
        tx_data <= 1'b1;
      end
      apb(1'b0, `LTS_ADDR_STATUS, 32'h0);
      chk({30'h0, q[1:0]}, {30'h0, em}, "mode read");
      if (em == 2'h3) begin
        apb(1'b1, `LTS_ADDR_LEADS, 32'hF);
        repeat (3) @(posedge sys_clk);
        chk({28'h0, lead22_o, lead8_o, lead5_o, lead4_o}, 32'hF, "program leads");
      end
    end
    // Far clock runs in bridge mode so the counters hold something to clear
    frame_on <= 1'b1;
    parity_err_in <= 1'b1;
    repeat (200) @(posedge sys_clk);
    parity_err_in <= 1'b0;
    frame_on <= 1'b0;
    repeat (40) @(posedge sys_clk);
    apb(1'b0, `LTS_ADDR_CNT_A, 32'h0);
    chk({31'h0, q != 32'h0}, 32'h1, "count A");
    apb(1'b0, `LTS_ADDR_CNT_B, 32'h0);
    chk({31'h0, q != 32'h0}, 32'h1, "count B");
    apb(1'b0, `LTS_ADDR_STATUS, 32'h0);
    chk({31'h0, q[`LTS_ST_PARITY]}, 32'h1, "parity set");
    // Store is never paired with the error rate test here
    apb(1'b1, `LTS_ADDR_PARAM, 32'h1);
    apb(1'b1, `LTS_ADDR_STORE, 32'h0);
    n = 0;
    do begin
      apb(1'b0, `LTS_ADDR_STATUS, 32'h0);
      n++;
    end while (q[`LTS_ST_BUSY] !== 1'b0 && n < 100);
    chk({31'h0, q[`LTS_ST_BUSY]}, 32'h0, "store done");
    chk({29'h0, q[5:3]}, 32'h3, "store flags");
    apb(1'b0, `LTS_ADDR_CNT_A, 32'h0);
    chk(q, 32'h0, "count A clear");
    apb(1'b0, `LTS_ADDR_CNT_B, 32'h0);
    chk(q, 32'h0, "count B clear");
    apb(1'b0, `LTS_ADDR_PARAM, 32'h0);
    chk(q, 32'h1, "params applied");
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, `LTS_ADDR_BCS, t);
      apb(1'b0, `LTS_ADDR_BCS, 32'h0);
      chk(q, t, "check type");
      apb(1'b0, `LTS_ADDR_ACC, 32'h0);
      // Odd parity applied: an all-zero corrected LRC shows bit 7 set
      chk(q, (t == 3) ? 32'h0000_FFFF : ((t == 0) ? 32'h0000_0080 : 32'h0),
        "accumulator start");
    end
    finish_test();
  end
endmodule
`default_nettype wire

// file: verif/lts_far_end.sv
// Far-end RS-232 equipment: drives the data leads and the receive clock.
// Assumes the bench turns frame_on on only while link traffic is wanted.
`default_nettype none
module lts_far_end (
  input wire logic frame_on,
  input wire logic lead2_o,
  input wire logic lead2_oe_n,
  input wire logic lead3_o,
  input wire logic lead3_oe_n,
  output var logic lead2_in,
  output var logic lead3_in,
  output var logic lead17_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Receive clock, still outside frames
  // ----------------------------------------------------------------
  logic far_bit = 1'b1;
  initial begin
    lead17_in = 1'b0;
    #3;
    forever begin
      #80;
      lead17_in = frame_on ? ~lead17_in : 1'b0;
    end
  end
  always @(posedge lead17_in) begin
    far_bit <= ~far_bit;
  end
  // ----------------------------------------------------------------
  // Lines: a simulated end is unplugged, so the block is sole driver
  // ----------------------------------------------------------------
  assign lead2_in = !lead2_oe_n ? lead2_o : far_bit;
  assign lead3_in = !lead3_oe_n ? lead3_o : ~far_bit;
endmodule
`default_nettype wire
